// *** src/zcd_top.sv ***
// Zero-cross detector control block with Wishbone register slave.
`timescale 1ns/1ps
`include "zcd_cfg.svh"
module zcd_top (
	input  wire logic        i_mclk,
	input  wire logic        i_rst_n,
	input  wire logic        i_por_detector_off,
	input  wire logic        i_sink_active,
	input  wire logic        i_wb_cyc,
	input  wire logic        i_wb_stb,
	input  wire logic        i_wb_we,
	input  wire logic [3:0]  i_wb_adr,
	input  wire logic [3:0]  i_wb_sel,
	input  wire logic [31:0] i_wb_dat,
	output logic      [31:0] o_wb_dat,
	output logic             o_wb_ack,
	output logic             o_detector_on,
	output logic             o_pin_force,
	output logic             o_irq
);
	logic rst_meta_reg;
	logic rst_sync_reg;
	logic rst_n;
	logic cfg_taken_reg;
	logic cfg_off_reg;
	zcd_pkg::zcd_ctrl_t ctrl_reg;
	zcd_pkg::zcd_wb_req_t req;
	logic module_off_reg;
	logic flag_reg;
	logic mask_reg;
	logic level;
	logic rise;
	logic fall;
	logic access;
	logic wr_ctrl;
	logic wr_stat;
	logic wr_mask;
	logic wr_moddis;
	logic active;
	logic event_hit;
	logic [7:0] ctrl_rd;

	////////////////////////////////////////////////////////////////////////////////
	// Reset release.
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end
	assign rst_n = rst_sync_reg;

	assign req = '{cyc: i_wb_cyc, stb: i_wb_stb, we: i_wb_we, adr: i_wb_adr, sel: i_wb_sel, dat: i_wb_dat};

	////////////////////////////////////////////////////////////////////////////////
	// Bus decode: single-cycle access answered one cycle after the request.
	assign access    = req.cyc & req.stb & ~o_wb_ack;
	assign wr_ctrl   = access & req.we & req.sel[0] & (req.adr == `ZCD_ADDR_CONTROL);
	assign wr_stat   = access & req.we & req.sel[0] & (req.adr == `ZCD_ADDR_STATUS);
	assign wr_mask   = access & req.we & req.sel[0] & (req.adr == `ZCD_ADDR_MASK);
	assign wr_moddis = access & req.we & req.sel[0] & (req.adr == `ZCD_ADDR_MODDIS);

	////////////////////////////////////////////////////////////////////////////////
	// Configuration bit is caught once after reset release.
	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_taken_reg <= 1'b0;
			cfg_off_reg   <= 1'b0;
		end else if (!cfg_taken_reg) begin
			cfg_taken_reg <= 1'b1;
			cfg_off_reg   <= i_por_detector_off;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Control register.
	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg <= '0;
		end else if (!cfg_taken_reg) begin
			ctrl_reg.enable <= ~i_por_detector_off;
		end else if (wr_ctrl) begin
			// Level and unused bits are not writable.
			ctrl_reg.enable  <= req.dat[`ZCD_BIT_EN] | ~cfg_off_reg;
			ctrl_reg.invert  <= req.dat[`ZCD_BIT_POL];
			ctrl_reg.rise_en <= req.dat[`ZCD_BIT_RISE_IRQ_ENABLE];
			ctrl_reg.fall_en <= req.dat[`ZCD_BIT_FALL_IRQ_ENABLE];
		end
	end

	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			module_off_reg <= 1'b0;
			mask_reg       <= 1'b0;
		end else begin
			if (wr_moddis) begin
				module_off_reg <= req.dat[0];
			end
			if (wr_mask) begin
				mask_reg <= req.dat[0];
			end
		end
	end

	// Module-disable only acts when the configuration lets software turn it off.
	assign active = ctrl_reg.enable & ~(module_off_reg & cfg_off_reg);

	////////////////////////////////////////////////////////////////////////////////
	// Output path; no clock gating, so sleep does not stop it.
	zcd_edge u_edge (
		.i_mclk        (i_mclk),
		.i_rst_n       (rst_n),
		.i_sink_active (i_sink_active),
		.i_invert      (ctrl_reg.invert),
		.o_level       (level),
		.o_rise        (rise),
		.o_fall        (fall)
	);

	assign event_hit = (rise & ctrl_reg.rise_en) | (fall & ctrl_reg.fall_en);

	// Set wins over a write-one clear in the same cycle.
	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			flag_reg <= `ZCD_IRQ_RESET;
		end else if (event_hit) begin
			flag_reg <= 1'b1;
		end else if (wr_stat & req.dat[0]) begin
			flag_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read path and outputs.
	always_comb begin
		ctrl_rd                 = 8'h00;
		ctrl_rd[`ZCD_BIT_EN]    = ctrl_reg.enable;
		ctrl_rd[`ZCD_BIT_OUT]   = level;
		ctrl_rd[`ZCD_BIT_POL]   = ctrl_reg.invert;
		ctrl_rd[`ZCD_BIT_RISE_IRQ_ENABLE]  = ctrl_reg.rise_en;
		ctrl_rd[`ZCD_BIT_FALL_IRQ_ENABLE]  = ctrl_reg.fall_en;
	end

	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			o_wb_ack <= 1'b0;
			o_wb_dat <= 32'h0000_0000;
		end else begin
			o_wb_ack <= access;
			if (access && !req.we) begin
				unique case (req.adr)
					`ZCD_ADDR_CONTROL: o_wb_dat <= {24'h00_0000, ctrl_rd};
					`ZCD_ADDR_STATUS:  o_wb_dat <= {31'h0000_0000, flag_reg};
					`ZCD_ADDR_MASK:    o_wb_dat <= {31'h0000_0000, mask_reg};
					`ZCD_ADDR_MODDIS:  o_wb_dat <= {31'h0000_0000, module_off_reg};
					default:           o_wb_dat <= 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			o_detector_on <= 1'b0;
			o_pin_force   <= 1'b0;
			o_irq         <= 1'b0;
		end else begin
			o_detector_on <= active;
			o_pin_force   <= active;
			o_irq         <= flag_reg & mask_reg;
		end
	end
endmodule : zcd_top

// *** src/zcd_cfg.svh ***
// Constants for the zero-cross detector control block.
// Behaviour
// - Detection and interrupts keep running in sleep.
// - Config bit clear: detector active from reset.
// - Config bit set: inactive until software enables.
// - Config bit clear: detector always enabled.
// - Module-disable bit switches off, subject to config.
// - Enable forces pin to source/sink current.
// - Enable reset value comes from configuration.
// - Level bit read-only, follows polarity.
// - Polarity bit inverts the logic output.
// - Rise enable sets flag on rising output.
// - Fall enable sets flag on falling output.
// - Bits 6, 3, 2 read zero, ignore writes.
// - Polarity and edge enables reset to zero.
// - Edge during flag clear leaves flag set.
// - Toggling polarity itself yields an edge.
`ifndef ZCD_CFG_SVH
`define ZCD_CFG_SVH
`define ZCD_ADDR_CONTROL 4'h0
`define ZCD_ADDR_STATUS  4'h4
`define ZCD_ADDR_MASK    4'h8
`define ZCD_ADDR_MODDIS  4'hC
`define ZCD_BIT_EN       7
`define ZCD_BIT_OUT      5
`define ZCD_BIT_POL      4
`define ZCD_BIT_RISE_IRQ_ENABLE     1
`define ZCD_BIT_FALL_IRQ_ENABLE     0
`define ZCD_CTRL_WMASK   8'h93
`define ZCD_IRQ_RESET    1'h0
`endif

// *** src/zcd_pkg.sv ***
// Types shared by the zero-cross detector control block.
package zcd_pkg;
	typedef struct packed {
		logic enable;
		logic invert;
		logic rise_en;
		logic fall_en;
	} zcd_ctrl_t;
	typedef struct packed {
		logic       cyc;
		logic       stb;
		logic       we;
		logic [3:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} zcd_wb_req_t;
endpackage : zcd_pkg

// *** src/zcd_edge.sv ***
// Synchroniser, polarity and edge detector of the detector output.
`timescale 1ns/1ps
module zcd_edge (
	input  wire logic i_mclk,
	input  wire logic i_rst_n,
	input  wire logic i_sink_active,
	input  wire logic i_invert,
	output logic      o_level,
	output logic      o_rise,
	output logic      o_fall
);
	logic meta_reg;
	logic sync_reg;
	logic level_reg;
	logic level_next;

	// Two stages; only the second is looked at.
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
		end else begin
			meta_reg <= i_sink_active;
			sync_reg <= meta_reg;
		end
	end

	// Output high while sinking unless inverted; a polarity change makes an edge.
	assign level_next = sync_reg ^ i_invert;

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			level_reg <= 1'b0;
		end else begin
			level_reg <= level_next;
		end
	end

	assign o_level = level_reg;
	assign o_rise  = level_next & ~level_reg;
	assign o_fall  = ~level_next & level_reg;
endmodule : zcd_edge

// *** testbench/zcd_monitor.sv ***
// Port checks for the zero-cross detector control block.
`timescale 1ns/1ps
module zcd_monitor (
	input wire logic        i_mclk,
	input wire logic        i_rst_n,
	input wire logic        i_por_detector_off,
	input wire logic        i_wb_stb,
	input wire logic        i_wb_we,
	input wire logic [3:0]  i_wb_adr,
	input wire logic [31:0] o_wb_dat,
	input wire logic        o_wb_ack,
	input wire logic        o_detector_on,
	input wire logic        o_pin_force
);
	logic [2:0] up_cnt;
	logic       rd;
	logic       on_cfg;
	assign rd = o_wb_ack && !i_wb_we;
	assign on_cfg = up_cnt == 3'h6 && !i_por_detector_off;
	// Counts cycles since reset so that start-up checks wait for the config load.
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) up_cnt <= 3'h0;
		else if (up_cnt != 3'h6) up_cnt <= up_cnt + 3'h1;
	end
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);
	a_pin_follows: assert property (o_pin_force == o_detector_on) else $error("pin force differs");
	a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack held");
	a_ack_answer: assert property (i_wb_stb && !o_wb_ack |=> o_wb_ack) else $error("ack late");
	a_ack_quiet: assert property (!i_wb_stb |=> !o_wb_ack) else $error("stray ack");
	a_cfg_on: assert property (on_cfg |-> o_detector_on) else $error("detector off");
	a_en_reads: assert property (rd && i_wb_adr == 4'h0 && on_cfg |-> o_wb_dat[7]) else $error("enable 0");
	a_rsvd_zero: assert property (rd && i_wb_adr == 4'h0 |->
		{o_wb_dat[31:8], o_wb_dat[6], o_wb_dat[3:2]} == 27'h000_0000) else $error("reserved set");
	a_unmapped: assert property (rd && i_wb_adr[1:0] != 2'h0 |-> o_wb_dat == 32'h0000_0000) else $error("hole");
endmodule : zcd_monitor
bind zcd_top zcd_monitor i_zcd_monitor (.*);

// *** testbench/zcd_ac_src.sv ***
// Behavioural AC source seen through the detector as sink or source state.
`timescale 1ns/1ps
module zcd_ac_src (
	input  wire logic i_step,
	output logic      o_sink_active
);
	initial o_sink_active = 1'b0;
	// Each step is one zero crossing, placed off the clock edge.
	always @(posedge i_step) o_sink_active <= #7 ~o_sink_active;
endmodule : zcd_ac_src

// *** testbench/test_zero_cross_detect_control.sv ***
// Self-checking bench for the zero-cross detector control block.
`timescale 1ns/1ps
module test_zero_cross_detect_control;
	logic        i_mclk = 1'b0;
	logic        i_rst_n = 1'b0;
	logic        cfg = 1'b1;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic        step = 1'b0;
	logic [3:0]  adr = 4'h0;
	logic [31:0] dat = 32'h0000_0000;
	logic [31:0] rdat;
	logic        ack, det_on, irq, sink;
	logic [31:0] exp_q[$];
	int          fail_count = 0;
	int          n_checks = 0;
	zcd_top i_zcd_top (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_por_detector_off(cfg), .i_sink_active(sink),
		.i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'h1), .i_wb_dat(dat),
		.o_wb_dat(rdat), .o_wb_ack(ack), .o_detector_on(det_on), .o_pin_force(), .o_irq(irq));
	zcd_ac_src i_zcd_ac_src (.i_step(step), .o_sink_active(sink));
	initial forever #12.5 i_mclk = ~i_mclk;
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		n_checks++;
		if (seen !== want) begin
			fail_count++;
			$display("mismatch at %0t: got %h want %h", $time, seen, want);
		end
	endtask : check
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : print_verdict
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge i_mclk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do @(posedge i_mclk); while (ack !== 1'b1);
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : bus
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, 32'h0000_0000);
	endtask : rd
	task automatic do_reset(input logic c);
		i_rst_n <= 1'b0;
		cfg <= c;
		repeat (3) @(posedge i_mclk);
		i_rst_n <= 1'b1;
		repeat (6) @(posedge i_mclk);
	endtask : do_reset
	// Read data is compared against the oldest expectation when ack shows.
	always @(posedge i_mclk) if (ack === 1'b1 && we === 1'b0) check(rdat, exp_q.pop_front());
	initial begin
		#100000;
		fail_count++;
		print_verdict();
	end
	initial begin
		logic       inv;
		logic [1:0] k;
		void'($urandom(32'h0000_159b));
		do_reset(1'b1);
		check(det_on, 32'h0000_0000);
		rd(4'h0, 32'h0000_0000);
		rd(4'h2, 32'h0000_0000);
		bus(1'b1, 4'h0, 32'h0000_00ff);
		repeat (8) @(posedge i_mclk);
		check(det_on, 32'h0000_0001);
		rd(4'h0, 32'h0000_00b3);
		rd(4'h4, 32'h0000_0001);
		bus(1'b1, 4'h8, 32'h0000_0001);
		repeat (2) @(posedge i_mclk);
		check(irq, 32'h0000_0001);
		bus(1'b1, 4'h4, 32'h0000_0001);
		repeat (2) @(posedge i_mclk);
		check(irq, 32'h0000_0000);
		// The next crossing and the write-one clear of the flag land on the same edge.
		step <= 1'b1;
		@(posedge i_mclk);
		bus(1'b1, 4'h4, 32'h0000_0001);
		step <= 1'b0;
		repeat (2) @(posedge i_mclk);
		check(irq, 32'h0000_0001);
		bus(1'b1, 4'h4, 32'h0000_0001);
		bus(1'b1, 4'hC, 32'h0000_0001);
		repeat (3) @(posedge i_mclk);
		check(det_on, 32'h0000_0000);
		bus(1'b1, 4'hC, 32'h0000_0000);
		for (int i = 0; i < 16; i++) begin
			k = i[2:1];
			inv = 1'($urandom % 2);
			bus(1'b1, 4'h0, {24'h00_0000, 2'h2, 1'b0, inv, 2'h0, k});
			repeat (8) @(posedge i_mclk);
			bus(1'b1, 4'h4, 32'h0000_0001);
			step <= 1'b1;
			repeat (8) @(posedge i_mclk);
			step <= 1'b0;
			rd(4'h4, {31'h0000_0000, (sink ^ inv) ? k[1] : k[0]});
			rd(4'h0, {24'h00_0000, 2'h2, sink ^ inv, inv, 2'h0, k});
		end
		do_reset(1'b0);
		check(det_on, 32'h0000_0001);
		bus(1'b1, 4'hC, 32'h0000_0001);
		repeat (3) @(posedge i_mclk);
		check(det_on, 32'h0000_0001);
		rd(4'h0, {24'h00_0000, 2'h2, sink, 5'h00});
		repeat (2) @(posedge i_mclk);
		print_verdict();
	end
endmodule : test_zero_cross_detect_control
